// File: design/ips_irq_pins.sv
// Interrupt pin routing, drive control and continuous axis sampling
//
// How it works
// - Two interrupt pins, each with independent drive and polarity settings.
// - Default routing: motion/sample request to pin a, FIFO request to pin b.
// - Drive controls live in register 0x33, bits 7:6 and 3:2.
// - Bit 2 sets pin a polarity: 0 active low, 1 active high.
// - Bit 3 sets pin a drive: 0 open-drain, 1 push-pull.
// - Bit 6 sets pin b polarity: 0 active low, 1 active high.
// - Bit 7 sets pin b drive: 0 open-drain, 1 push-pull.
// - Swap bit (0x31 bit 4) exchanges which request feeds which pin.
// - Swap moves only requests; drive and polarity stay with the pin.
// - Merge bit (0x2D bit 3) ORs FIFO request into the first request.
// - While merged, the second request is held inactive.
// - Merge plus swap puts the merged request on pin b.
// - Axis result registers refresh every output period without host action.
// - With enable set, every axis refresh raises the sample update request.
// - Rate register 0x08 codes 0x08..0x0F select 50 to 2000 Hz.
`include "ips_regs.svh"
`default_nettype none
module ips_irq_pins
  import ips_pkg::*;
#(
  parameter int          CLK_HZ = 100_000_000,
  parameter int unsigned AXIS_W = 16
)(
  // Clock and reset
  input  wire  logic              mclk,
  input  wire  logic              reset_n,
  // Register port from the serial host interface
  input  wire  logic [7:0]        reg_addr,
  input  wire  logic [7:0]        reg_wdata,
  input  wire  logic              reg_wr,
  output logic [7:0]              reg_rdata,
  // Sensing core inputs
  input  wire  logic [AXIS_W-1:0] x_axis_in,
  input  wire  logic [AXIS_W-1:0] y_axis_in,
  input  wire  logic [AXIS_W-1:0] z_axis_in,
  input  wire  logic              motion_event,
  input  wire  logic              fifo_request,
  // Sample strobe to the rest of the device
  output logic                    sample_tick,
  // Interrupt pins
  output logic                    irq_pin_a_o,
  output logic                    irq_pin_a_oe,
  output logic                    irq_pin_b_o,
  output logic                    irq_pin_b_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Rate decode

  // Output period in clock cycles for a rate code, rounded down
  function automatic ips_count_t period_of(input ips_byte_t code);
    ips_count_t hz;
    hz = `IPS_HZ_50;
    case (code)
      IPS_RATE_50:   hz = `IPS_HZ_50;
      IPS_RATE_100:  hz = `IPS_HZ_100;
      IPS_RATE_125:  hz = `IPS_HZ_125;
      IPS_RATE_200:  hz = `IPS_HZ_200;
      IPS_RATE_250:  hz = `IPS_HZ_250;
      IPS_RATE_500:  hz = `IPS_HZ_500;
      IPS_RATE_1000: hz = `IPS_HZ_1000;
      IPS_RATE_2000: hz = `IPS_HZ_2000;
      default:       hz = `IPS_HZ_50; // Undefined codes run at slowest rate
    endcase
    return ips_count_t'(CLK_HZ) / hz;
  endfunction : period_of

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  ips_byte_t       pin_drive_r;
  ips_byte_t       rate_r;
  logic            merge_r;
  logic            swap_r;
  logic            sample_irq_en_r;
  logic            sample_update_irq_r;
  logic            wr_drive;
  logic            wr_clear;
  logic [AXIS_W-1:0] x_axis_result_r;
  logic [AXIS_W-1:0] y_axis_result_r;
  logic [AXIS_W-1:0] z_axis_result_r;
  ips_count_t      period_cnt_r;
  logic            tick_r;

  assign wr_drive = reg_wr && (reg_addr == `IPS_OFS_PIN_DRIVE);
  assign wr_clear = reg_wr && (reg_addr == `IPS_OFS_CLEAR);

  // drive register, only the four documented bits are kept
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      pin_drive_r <= `IPS_RST_PIN_DRIVE;
    else if (wr_drive)
      pin_drive_r <= reg_wdata & `IPS_MSK_PIN_DRIVE;
  end

  // rate, merge, swap and enable control writes
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      rate_r          <= `IPS_RST_RATE;
      merge_r         <= 1'b0;
      swap_r          <= 1'b0;
      sample_irq_en_r <= 1'b0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `IPS_OFS_RATE:   rate_r          <= reg_wdata;
        `IPS_OFS_MERGE:  merge_r         <= reg_wdata[`IPS_BIT_MERGE];
        `IPS_OFS_SWAP:   swap_r          <= reg_wdata[`IPS_BIT_SWAP];
        `IPS_OFS_IRQ_EN: sample_irq_en_r <= reg_wdata[`IPS_BIT_SAMPLE_IRQ];
        default:         ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Continuous sampling

  // free-running output period counter; a rate change restarts it
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      period_cnt_r <= '0;
      tick_r       <= 1'b0;
    end
    else if (reg_wr && reg_addr == `IPS_OFS_RATE)
    begin
      period_cnt_r <= '0;
      tick_r       <= 1'b0;
    end
    else if (period_cnt_r >= period_of(rate_r) - 1)
    begin
      period_cnt_r <= '0;
      tick_r       <= 1'b1;
    end
    else
    begin
      period_cnt_r <= period_cnt_r + 1;
      tick_r       <= 1'b0;
    end
  end

  assign sample_tick = tick_r;

  // axis results refreshed on each period tick
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      x_axis_result_r <= '0;
      y_axis_result_r <= '0;
      z_axis_result_r <= '0;
    end
    else if (tick_r)
    begin
      x_axis_result_r <= x_axis_in;
      y_axis_result_r <= y_axis_in;
      z_axis_result_r <= z_axis_in;
    end
  end

  // sticky update request; a fresh sample beats a same-cycle clear
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      sample_update_irq_r <= 1'b0;
    else if (tick_r && sample_irq_en_r)
      sample_update_irq_r <= 1'b1;
    else if (wr_clear && reg_wdata[`IPS_BIT_SAMPLE_IRQ])
      sample_update_irq_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request routing

  logic motion_sample_request;
  logic req_first;
  logic req_second;
  logic [1:0] pin_req;
  logic [1:0] pin_ah;
  logic [1:0] pin_pp;
  logic [1:0] pin_o_r;
  logic [1:0] pin_oe_r;

  // first request is motion plus sample update
  assign motion_sample_request = motion_event | sample_update_irq_r;
  // merge folds the FIFO request into the first request
  assign req_first  = motion_sample_request | (merge_r & fifo_request);
  // merged mode silences the second request
  assign req_second = fifo_request & ~merge_r;
  // swap exchanges the sources; follows from merge plus swap
  assign pin_req[0] = swap_r ? req_second : req_first;
  assign pin_req[1] = swap_r ? req_first  : req_second;

  // settings indexed by physical pin, never by request
  assign pin_ah[0] = pin_drive_r[`IPS_BIT_A_ACTIVE_HIGH];
  assign pin_pp[0] = pin_drive_r[`IPS_BIT_A_PUSH_PULL];
  assign pin_ah[1] = pin_drive_r[`IPS_BIT_B_ACTIVE_HIGH];
  assign pin_pp[1] = pin_drive_r[`IPS_BIT_B_PUSH_PULL];

  // identical, independent output stage per pin
  for (genvar p = 0; p < 2; p++)
  begin : g_pin
    logic o_r;
    logic oe_r;
    always_ff @(posedge mclk)
    begin
      if (!reset_n)
      begin
        // Reset drive bits read zero: open-drain, released
        o_r  <= 1'b0;
        oe_r <= 1'b0;
      end
      else if (pin_pp[p])
      begin
        // push-pull always drives; picks the asserted level
        o_r  <= pin_req[p] ? pin_ah[p] : ~pin_ah[p];
        oe_r <= 1'b1;
      end
      else
      begin
        // open-drain pulls low only for an active-low assertion
        o_r  <= 1'b0;
        oe_r <= pin_req[p] & ~pin_ah[p];
      end
    end
    // Flops local to each pin so no variable has two writing processes
    assign pin_o_r[p]  = o_r;
    assign pin_oe_r[p] = oe_r;
  end

  // pin b settings come from bits 6 and 7
  assign irq_pin_a_o  = pin_o_r[0];
  assign irq_pin_a_oe = pin_oe_r[0];
  assign irq_pin_b_o  = pin_o_r[1];
  assign irq_pin_b_oe = pin_oe_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // Read-back

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      reg_rdata <= `IPS_RST_BYTE;
    else
    begin
      case (reg_addr)
        `IPS_OFS_PIN_DRIVE: reg_rdata <= pin_drive_r;
        `IPS_OFS_RATE:      reg_rdata <= rate_r;
        `IPS_OFS_MERGE:     reg_rdata <= 8'(merge_r) << `IPS_BIT_MERGE;
        `IPS_OFS_SWAP:      reg_rdata <= 8'(swap_r) << `IPS_BIT_SWAP;
        `IPS_OFS_IRQ_EN:    reg_rdata <= 8'(sample_irq_en_r);
        `IPS_OFS_STATUS:    reg_rdata <= 8'(sample_update_irq_r);
        `IPS_OFS_X_LO:      reg_rdata <= x_axis_result_r[7:0];
        `IPS_OFS_X_HI:      reg_rdata <= x_axis_result_r[AXIS_W-1 -: 8];
        `IPS_OFS_Y_LO:      reg_rdata <= y_axis_result_r[7:0];
        `IPS_OFS_Y_HI:      reg_rdata <= y_axis_result_r[AXIS_W-1 -: 8];
        `IPS_OFS_Z_LO:      reg_rdata <= z_axis_result_r[7:0];
        `IPS_OFS_Z_HI:      reg_rdata <= z_axis_result_r[AXIS_W-1 -: 8];
        default:            reg_rdata <= `IPS_RST_BYTE;
      endcase
    end
  end

endmodule : ips_irq_pins
`default_nettype wire

// File: design/ips_regs.svh
// Register offsets, field positions and reset values of the interrupt pin block
`ifndef IPS_REGS_SVH
`define IPS_REGS_SVH

// Register offsets
`define IPS_OFS_RATE      8'h08
`define IPS_OFS_MERGE     8'h2d
`define IPS_OFS_SWAP      8'h31
`define IPS_OFS_PIN_DRIVE 8'h33
`define IPS_OFS_IRQ_EN    8'h06
`define IPS_OFS_STATUS    8'h13
`define IPS_OFS_CLEAR     8'h14
`define IPS_OFS_X_LO      8'h0d
`define IPS_OFS_X_HI      8'h0e
`define IPS_OFS_Y_LO      8'h0f
`define IPS_OFS_Y_HI      8'h10
`define IPS_OFS_Z_LO      8'h11
`define IPS_OFS_Z_HI      8'h12

// Field positions
`define IPS_BIT_A_ACTIVE_HIGH 2
`define IPS_BIT_A_PUSH_PULL   3
`define IPS_BIT_B_ACTIVE_HIGH 6
`define IPS_BIT_B_PUSH_PULL   7
`define IPS_BIT_SWAP          4
`define IPS_BIT_MERGE         3
`define IPS_BIT_SAMPLE_IRQ    0

// Reset values and masks
`define IPS_RST_PIN_DRIVE 8'h00
`define IPS_MSK_PIN_DRIVE 8'hcc
`define IPS_RST_RATE      8'h08
`define IPS_RST_BYTE      8'h00

// Wake-mode rates in Hz
`define IPS_HZ_50   50
`define IPS_HZ_100  100
`define IPS_HZ_125  125
`define IPS_HZ_200  200
`define IPS_HZ_250  250
`define IPS_HZ_500  500
`define IPS_HZ_1000 1000
`define IPS_HZ_2000 2000

`endif

// File: design/ips_pkg.sv
// Types shared by the interrupt pin block
`default_nettype none
package ips_pkg;
  typedef logic [7:0] ips_byte_t;
  typedef logic [31:0] ips_count_t;
  // Wake-mode rate codes
  typedef enum logic [7:0] {
    IPS_RATE_50   = 8'h08,
    IPS_RATE_100  = 8'h09,
    IPS_RATE_125  = 8'h0a,
    IPS_RATE_200  = 8'h0b,
    IPS_RATE_250  = 8'h0c,
    IPS_RATE_500  = 8'h0d,
    IPS_RATE_1000 = 8'h0e,
    IPS_RATE_2000 = 8'h0f
  } ips_rate_t;
endpackage : ips_pkg
`default_nettype wire

// File: test/ips_host_model.sv
// Host side of the two interrupt lines: pull-ups and line resolution
`default_nettype none
module ips_host_model
(
  // Pin drivers from the device
  input  wire logic a_o,
  input  wire logic a_oe,
  input  wire logic b_o,
  input  wire logic b_oe,
  // Line levels seen by the host
  output logic      lvl_a,
  output logic      lvl_b
);
  timeunit 1ns;
  timeprecision 100ps;
  // released line pulls up
  // A released line must read high, never a stale driven value
  assign lvl_a = a_oe ? a_o : 1'b1;
  assign lvl_b = b_oe ? b_o : 1'b1;
endmodule : ips_host_model
`default_nettype wire

// File: test/ips_irq_pins_checker.sv
// Assertions on pin routing, drive modes, readback and sample strobe
`default_nettype none
module ips_irq_pins_checker
  import ips_pkg::*;
(
  // Clock, reset and register port
  input wire logic       mclk,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_rdata,
  // Requests and strobe
  input wire logic       motion_event,
  input wire logic       fifo_request,
  input wire logic       sample_tick,
  // Pins
  input wire logic       irq_pin_a_o,
  input wire logic       irq_pin_a_oe,
  input wire logic       irq_pin_b_o,
  input wire logic       irq_pin_b_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] drv_r;
  logic       swap_r;
  logic       merge_r;
  logic       sec;
  // Shadow of the settings; only the stored bits are kept
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      drv_r   <= 8'h00;
      swap_r  <= 1'b0;
      merge_r <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 8'h33)
        drv_r <= reg_wdata & 8'hcc;
      if (reg_addr == 8'h31)
        swap_r <= reg_wdata[4];
      if (reg_addr == 8'h2d)
        merge_r <= reg_wdata[3];
    end
  end
  // Second request: the fifo unless merged away
  assign sec = fifo_request & ~merge_r;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////
  a_drive_readback: assert property ($past(reg_addr) == 8'h33
    |-> reg_rdata == $past(drv_r)) else $error("drive readback wrong");
  a_a_od_low: assert property (!$past(drv_r[3]) |-> !irq_pin_a_o)
    else $error("open-drain pin a driven high");
  a_b_od_drive: assert property ($past(reset_n && !drv_r[7] && !swap_r)
    |-> !irq_pin_b_o && irq_pin_b_oe == $past(sec && !drv_r[6])) else $error("pin b od");
  a_b_pp_level: assert property ($past(reset_n && drv_r[7] && !swap_r)
    |-> irq_pin_b_oe && irq_pin_b_o == $past(sec ~^ drv_r[6])) else $error("pin b pp");
  a_swap_to_a: assert property ($past(reset_n && drv_r[3] && swap_r)
    |-> irq_pin_a_o == $past(sec ~^ drv_r[2])) else $error("swap to pin a");
  a_first_on_a: assert property ($past(reset_n && drv_r[3] && !swap_r &&
    (motion_event || merge_r && fifo_request)) |-> irq_pin_a_o == $past(drv_r[2]))
    else $error("first request on pin a");
  a_merge_to_b: assert property ($past(reset_n && drv_r[7] && swap_r &&
    (motion_event || merge_r && fifo_request)) |-> irq_pin_b_o == $past(drv_r[6]))
    else $error("merged request on pin b");
  a_tick_single: assert property (sample_tick |=> !sample_tick)
    else $error("sample strobe too long");
  c_merge_swap: cover property ($past(swap_r && merge_r) && irq_pin_b_o);
  c_tick: cover property (sample_tick);
  c_od_drive: cover property (irq_pin_b_oe && !irq_pin_b_o);
endmodule : ips_irq_pins_checker
`default_nettype wire

// File: test/tb.sv
// Testbench for pin routing, drive modes, readback and sampling
`default_nettype none
module tb;
  import ips_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HZ = 100000;
  logic        mclk = 1'b0;
  logic        reset_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        mot = 1'b0;
  logic        fifo = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic [7:0]  d;
  logic [15:0] xin = 16'h1234;
  logic [15:0] yin = 16'h5678;
  logic [15:0] zin = 16'h9abc;
  logic        tick, a_o, a_oe, b_o, b_oe, lvl_a, lvl_b;
  int          failures = 0;
  int          checked = 0;
  int          cyc = 0;
  int          n;
  ips_irq_pins #(.CLK_HZ(HZ)) ips_irq_pins_i (.mclk(mclk), .reset_n(reset_n),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rdata(rdata),
    .x_axis_in(xin), .y_axis_in(yin), .z_axis_in(zin), .motion_event(mot),
    .fifo_request(fifo), .sample_tick(tick), .irq_pin_a_o(a_o), .irq_pin_a_oe(a_oe),
    .irq_pin_b_o(b_o), .irq_pin_b_oe(b_oe));
  ips_host_model ips_host_model_i (.a_o(a_o), .a_oe(a_oe), .b_o(b_o), .b_oe(b_oe),
    .lvl_a(lvl_a), .lvl_b(lvl_b));
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask : chk
  // Expected line level; active-high open-drain never pulls
  function automatic logic lvl(input logic pp, input logic ah, input logic req);
    return pp ? (req ~^ ah) : !(req & !ah);
  endfunction : lvl
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    #1;
    addr = a;
    wdata = v;
    reg_wr = 1'b1;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge mclk);
    #1;
    addr = a;
    @(posedge mclk);
    #1;
    v = rdata;
  endtask : rd
  // Pins lag settings by two edges
  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle
  task automatic wtick(output int k);
    k = 0;
    do
    begin
      @(posedge mclk);
      #1;
      k++;
    end
    while (tick !== 1'b1 && k < 3000);
  endtask : wtick
  ////////////////////////////////////////////////////////////////////////
  task automatic t_drive;
    logic [7:0] w;
    for (int i = 0; i < 64; i++)
    begin
      w = {i[0], i[1], 2'h3, i[2], i[3], 2'h3};
      wr(8'h33, w);
      mot = i[4];
      fifo = i[5];
      settle();
      chk(lvl_a, lvl(i[2], i[3], i[4]), "pin a");
      chk(lvl_b, lvl(i[0], i[1], i[5]), "pin b");
      rd(8'h33, d);
      chk(d, w & 8'hcc, "drive reg");
    end
  endtask : t_drive
  task automatic t_route;
    logic f, s;
    wr(8'h33, 8'h8c);
    for (int i = 0; i < 16; i++)
    begin
      wr(8'h31, {3'h0, i[0], 4'h0});
      wr(8'h2d, {4'h0, i[1], 3'h0});
      mot = i[2];
      fifo = i[3];
      settle();
      f = i[2] | (i[1] & i[3]);
      s = i[3] & ~i[1];
      chk(lvl_a, i[0] ? s : f, "route a");
      chk(lvl_b, !(i[0] ? f : s), "route b");
    end
  endtask : t_route
  task automatic t_sample;
    wr(8'h31, 8'h00);
    wr(8'h2d, 8'h00);
    mot = 1'b0;
    fifo = 1'b0;
    wr(8'h08, 8'h0f);
    wtick(n);
    settle();
    rd(8'h0d, d);
    chk(d, xin[7:0], "x lo");
    rd(8'h10, d);
    chk(d, yin[15:8], "y hi");
    rd(8'h11, d);
    chk(d, zin[7:0], "z lo");
    wr(8'h06, 8'h01);
    wtick(n);
    settle();
    chk(lvl_a, 1'b1, "sample irq");
    rd(8'h13, d);
    chk(d[0], 1'b1, "status");
    wr(8'h06, 8'h00);
    wr(8'h14, 8'h01);
    settle();
    chk(lvl_a, 1'b0, "irq cleared");
  endtask : t_sample
  task automatic t_rates;
    int hz [8] = '{50, 100, 125, 200, 250, 500, 1000, 2000};
    for (int k = 0; k < 8; k++)
    begin
      wr(8'h08, 8'h08 + k[7:0]);
      wtick(n);
      wtick(n);
      chk(n[15:0], 16'(HZ / hz[k]), "period");
    end
  endtask : t_rates
  task automatic conclude;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude
  // Hang guard well above the expected run length
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      failures++;
      conclude();
    end
  end
  initial
  begin
    repeat (16) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    rd(8'h33, d);
    chk(d, 8'h00, "drive reset");
    chk(lvl_a & lvl_b, 1'b1, "released");
    t_drive();
    t_route();
    t_sample();
    t_rates();
    conclude();
  end
endmodule : tb
bind ips_irq_pins ips_irq_pins_checker ips_irq_pins_checker_i (.mclk(mclk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rdata(reg_rdata), .motion_event(motion_event), .fifo_request(fifo_request),
  .sample_tick(sample_tick), .irq_pin_a_o(irq_pin_a_o), .irq_pin_a_oe(irq_pin_a_oe),
  .irq_pin_b_o(irq_pin_b_o), .irq_pin_b_oe(irq_pin_b_oe));
`default_nettype wire
